// [circ_wrap.v]
// circular buffer wrap for an updated index register
`timescale 1ns/1ps
module circ_wrap #(
  parameter AW = 32
) (
  input  wire [AW-1:0] index_old,
  input  wire [AW-1:0] step,
  input  wire          step_down,
  input  wire [AW-1:0] length,
  input  wire [AW-1:0] base,
  output reg  [AW-1:0] index_new
);
  reg [AW-1:0] raw;
  // length zero gives linear addressing; otherwise fold into the buffer
  always @* begin
    raw = step_down ? index_old - step : index_old + step;
    index_new = raw;
    if (length != {AW{1'b0}}) begin
      if (!step_down && raw >= base + length)
        index_new = raw - length;
      else if (step_down && raw < base)
        index_new = raw + length;
    end
  end
endmodule // circ_wrap

// [data_mem_model.sv]
// data memory model keeping the last stored word
`timescale 1ns/1ps
module data_mem_model (
  input  logic        clk_sys, mem_write,
  input  logic [31:0] mem_addr, mem_data,
  input  logic [3:0]  mem_byte_en,
  output logic [31:0] word
);
  // merge only enabled lanes, so a half store leaves the rest alone
  always @(posedge clk_sys)
    if (mem_write)
      for (int i = 0; i < 4; i++)
        if (mem_byte_en[i]) word[8*i+:8] <= mem_data[8*i+:8];
endmodule // data_mem_model

// [store_address_unit.v]
// store path: address forming, alignment check and pointer update
// Notes on behaviour
// - word store writes whole data register
// - word address must be multiple of four
// - word post-modify steps pointer by four
// - short offset zero to sixty, multiple four
// - long offset up to 131068, add or subtract
// - frame form subtracts four to 128
// - long offset forms are 32-bit encodings
// - 32-bit encodings refuse parallel issue
// - base may be pointer, index, frame
// - store then add second register to first
// - same register twice: store, no update
// - index updates wrap through length register
// - index, length, base left uninitialised
// - high-half store writes upper sixteen bits
// - high-half address must be even
// - high-half index post-modify by two
`timescale 1ns/1ps
`include "store_unit_defs.vh"
module store_address_unit #(
  parameter AW = 32,
  parameter DW = 32
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          issue,
  input  wire          kind,
  input  wire [2:0]    mode,
  input  wire [1:0]    base_class,
  input  wire          same_pointer,
  input  wire          parallel_req,
  input  wire [DW-1:0] store_data,
  input  wire [AW-1:0] base_value,
  input  wire [AW-1:0] index_step,
  input  wire [16:0]   offset,
  input  wire [AW-1:0] circ_length,
  input  wire [AW-1:0] circ_base,
  output reg           mem_write,
  output reg  [AW-1:0] mem_addr,
  output reg  [DW-1:0] mem_data,
  output reg  [3:0]    mem_byte_en,
  output reg           misaligned,
  output reg           bad_form,
  output reg           parallel_refused,
  output reg           long_encoding,
  output reg           base_write,
  output reg  [AW-1:0] base_next
);
  reg [AW-1:0] next_addr;
  reg          long_form;
  reg          form_ok;
  reg          align_ok;
  reg          updates;
  reg          step_down;
  reg [AW-1:0] step;
  wire [AW-1:0] wrapped;
  wire [AW-1:0] ofs_ext;

  assign ofs_ext = {{(AW-17){1'b0}}, offset};

  // index forms wrap through their length register; no reset values
  // are applied to length or base since software owns them
  circ_wrap #(.AW(AW)) u_wrap (
    .index_old (base_value),
    .step      (step),
    .step_down (step_down),
    .length    (circ_length),
    .base      (circ_base),
    .index_new (wrapped)
  );

  // decode the form: address, legality and post-modify
  always @* begin
    next_addr = base_value;
    long_form = 1'b0;
    form_ok   = 1'b1;
    updates   = 1'b0;
    step_down = 1'b0;
    step      = (kind == `KIND_WORD) ? `WORD_STEP : `HALF_STEP;
    case (mode)
      `MODE_PLAIN: begin
        next_addr = base_value;
      end
      `MODE_POST_INC: begin
        updates = 1'b1;
      end
      `MODE_POST_DEC: begin
        updates   = 1'b1;
        step_down = 1'b1;
      end
      `MODE_SHORT_OFS: begin
        next_addr = base_value + ofs_ext;
        form_ok = (offset <= `SHORT_OFS_MAX) && (offset[1:0] == 2'h0);
      end
      `MODE_LONG_ADD: begin
        next_addr = base_value + ofs_ext;
        long_form = 1'b1;
        form_ok   = offset[1:0] == 2'h0;
      end
      `MODE_LONG_SUB: begin
        next_addr = base_value - ofs_ext;
        long_form = 1'b1;
        form_ok   = offset[1:0] == 2'h0;
      end
      `MODE_FRAME_NEG: begin
        next_addr = base_value - ofs_ext;
        form_ok = (base_class == `BASE_FRAME) &&
                  (offset >= `FRAME_OFS_MIN) &&
                  (offset <= `FRAME_OFS_MAX) &&
                  (offset[1:0] == 2'h0);
      end
      `MODE_REG_INDEX: begin
        step    = index_step;
        updates = !same_pointer;
      end
      default: begin
        form_ok = 1'b0;
      end
    endcase
    // offset forms are word-only; high-half takes index or pointer only
    if (kind == `KIND_HIGH_HALF) begin
      if (mode != `MODE_PLAIN && mode != `MODE_POST_INC &&
          mode != `MODE_POST_DEC && mode != `MODE_REG_INDEX)
        form_ok = 1'b0;
      if (base_class == `BASE_FRAME)
        form_ok = 1'b0;
      if ((mode == `MODE_POST_INC || mode == `MODE_POST_DEC) &&
          base_class != `BASE_INDEX)
        form_ok = 1'b0;
    end
    if (mode == `MODE_REG_INDEX && base_class == `BASE_FRAME)
      form_ok = 1'b0;
    if (base_class == 2'h3)
      form_ok = 1'b0;
    align_ok = (kind == `KIND_WORD) ? (next_addr[1:0] == 2'h0)
                                    : (next_addr[0] == 1'b0);
  end

  // next values of every output, and the pieces they are built from
  reg          next_mem_write;
  reg          next_misaligned;
  reg          next_bad_form;
  reg          next_parallel_refused;
  reg          next_long_encoding;
  reg          next_base_write;
  reg [AW-1:0] next_base_next;
  reg [AW-1:0] next_mem_addr;
  reg [DW-1:0] next_mem_data;
  reg [3:0]    next_mem_byte_en;
  reg [DW-1:0] lane_data;
  reg [3:0]    lane_byte_en;
  reg [AW-1:0] linear_next;
  reg [AW-1:0] update_value;
  wire         word_kind;
  wire [15:0]  upper_half;

  assign word_kind  = (kind == `KIND_WORD);
  assign upper_half = store_data[`UPPER_HI:`UPPER_LO];

  // exactly one answer per taken request, in priority order: a bad form
  // hides a parallel clash, which in turn hides a misalignment
  always @* begin
    next_mem_write        = 1'b0;
    next_misaligned       = 1'b0;
    next_bad_form         = 1'b0;
    next_parallel_refused = 1'b0;
    if (issue) begin
      if (!form_ok) begin
        next_bad_form = 1'b1;
      end else if (long_form && parallel_req) begin
        next_parallel_refused = 1'b1;
      end else if (!align_ok) begin
        next_misaligned = 1'b1;
      end else begin
        next_mem_write = 1'b1;
      end
    end
  end

  // word stores fill every lane; a half store repeats the upper half on
  // both halves so the memory finds it whichever lane the address hits
  always @* begin
    if (word_kind) begin
      lane_data    = store_data;
      lane_byte_en = 4'hf;
    end else begin
      lane_data = {2{upper_half}};
      if (next_addr[1])
        lane_byte_en = 4'hc;
      else
        lane_byte_en = 4'h3;
    end
  end

  // pointer and frame registers step linearly; only index registers
  // see the wrap, so a stale length cannot disturb a pointer walk
  always @* begin
    if (step_down)
      linear_next = base_value - step;
    else
      linear_next = base_value + step;
  end

  // the update starts from the value used as the store address
  always @* begin
    if (base_class == `BASE_INDEX)
      update_value = wrapped;
    else
      update_value = linear_next;
  end

  // write-back only follows a store that really happened
  always @* begin
    next_base_write = next_mem_write && updates;
    next_base_next  = base_next;
    if (next_base_write)
      next_base_next = update_value;
  end

  // address held between stores so the memory may sample it late
  always @* begin
    next_mem_addr = mem_addr;
    if (next_mem_write)
      next_mem_addr = next_addr;
  end

  // data and lane enables keep the last store's values between stores
  always @* begin
    next_mem_data    = mem_data;
    next_mem_byte_en = mem_byte_en;
    if (next_mem_write) begin
      next_mem_data    = lane_data;
      next_mem_byte_en = lane_byte_en;
    end
  end

  // encoding length follows every taken request, even a refused one
  always @* begin
    next_long_encoding = long_encoding;
    if (issue)
      next_long_encoding = long_form;
  end

  // store strobe, one cycle per store; no arithmetic flag path exists
  // here and no privilege check, so every mode may store
  always @(posedge clk_sys) begin
    if (rst) begin
      mem_write <= 1'b0;
    end else begin
      mem_write <= next_mem_write;
    end
  end

  // misaligned exception pulse; the store itself is dropped
  always @(posedge clk_sys) begin
    if (rst) begin
      misaligned <= 1'b0;
    end else begin
      misaligned <= next_misaligned;
    end
  end

  // illegal combination pulse, nothing written and nothing updated
  always @(posedge clk_sys) begin
    if (rst) begin
      bad_form <= 1'b0;
    end else begin
      bad_form <= next_bad_form;
    end
  end

  // refusal pulse for a long encoding paired with another instruction
  always @(posedge clk_sys) begin
    if (rst) begin
      parallel_refused <= 1'b0;
    end else begin
      parallel_refused <= next_parallel_refused;
    end
  end

  // level telling which encoding length was last taken
  always @(posedge clk_sys) begin
    if (rst) begin
      long_encoding <= 1'b0;
    end else begin
      long_encoding <= next_long_encoding;
    end
  end

  // effective address register
  always @(posedge clk_sys) begin
    if (rst) begin
      mem_addr <= {AW{1'b0}};
    end else begin
      mem_addr <= next_mem_addr;
    end
  end

  // store data register
  always @(posedge clk_sys) begin
    if (rst) begin
      mem_data <= {DW{1'b0}};
    end else begin
      mem_data <= next_mem_data;
    end
  end

  // lane enable register
  always @(posedge clk_sys) begin
    if (rst) begin
      mem_byte_en <= 4'h0;
    end else begin
      mem_byte_en <= next_mem_byte_en;
    end
  end

  // write-back strobe toward the address register file
  always @(posedge clk_sys) begin
    if (rst) begin
      base_write <= 1'b0;
    end else begin
      base_write <= next_base_write;
    end
  end

  // updated address register value, valid while base_write is high
  always @(posedge clk_sys) begin
    if (rst) begin
      base_next <= {AW{1'b0}};
    end else begin
      base_next <= next_base_next;
    end
  end
endmodule // store_address_unit

// [store_address_unit_bench.sv]
// bench for the store address unit
`timescale 1ns/1ps
module store_address_unit_bench;
  logic clk_sys = 0, rst = 1, issue = 0, kind = 0, same_pointer = 0;
  logic parallel_req = 0, mem_write, misaligned, bad_form, parallel_refused;
  logic long_encoding, base_write;
  logic [2:0] mode = 0;
  logic [1:0] base_class = 0;
  logic [16:0] offset = 0;
  logic [31:0] store_data = 0, base_value = 0, index_step = 0, circ_length = 0;
  logic [31:0] circ_base = 0, mem_addr, mem_data, base_next, word;
  logic [3:0] mem_byte_en;
  int fail_count = 0, total_checks = 0;
  always #20 clk_sys = ~clk_sys;
  store_address_unit u_dut (.*);
  data_mem_model u_mem (.*);
  task ck(input [63:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one request; results are settled 1 ns after the taking edge
  task st(input k, input [2:0] m, input [1:0] c, input [31:0] b, [16:0] o);
    @(posedge clk_sys) #1;
    kind = k;
    mode = m;
    base_class = c;
    base_value = b;
    offset = o;
    issue = 1;
    @(posedge clk_sys) #1;
    issue = 0;
  endtask
  task t_word;
    store_data = 32'h12345678;
    st(0, 3'h0, 2'h0, 32'h100, 0);
    ck(mem_addr, 32'h100);
    ck(mem_byte_en, 4'hf);
    @(posedge clk_sys) #1;
    ck(word, 32'h12345678);
  endtask
  task t_post;
    index_step = 32'h10;
    st(0, 3'h1, 2'h0, 32'h200, 0);
    ck(base_next, 32'h204);
    st(0, 3'h2, 2'h0, 32'h200, 0);
    ck(base_next, 32'h1fc);
    st(0, 3'h7, 2'h0, 32'h300, 0);
    ck({mem_addr, base_next}, {32'h300, 32'h310});
    same_pointer = 1;
    st(0, 3'h7, 2'h0, 32'h400, 0);
    ck({mem_write, base_write, mem_addr}, {2'h2, 32'h400});
    same_pointer = 0;
  endtask
  task t_ofs;
    st(0, 3'h3, 2'h0, 32'h100, 17'h0003c);
    ck({long_encoding, mem_addr}, {1'h0, 32'h13c});
    st(0, 3'h4, 2'h0, 32'h0, 17'h1fffc);
    ck({long_encoding, mem_addr}, {1'h1, 32'h1fffc});
    st(0, 3'h5, 2'h0, 32'h100, 17'h00004);
    ck(mem_addr, 32'hfc);
    st(0, 3'h6, 2'h2, 32'h1000, 17'h00080);
    ck({mem_write, mem_addr}, {1'h1, 32'hf80});
  endtask
  task t_refuse;
    parallel_req = 1;
    st(0, 3'h4, 2'h0, 32'h100, 17'h00008);
    ck({parallel_refused, mem_write}, 2'h2);
    st(0, 3'h3, 2'h0, 32'h100, 17'h00008);
    ck({parallel_refused, mem_write}, 2'h1);
    parallel_req = 0;
  endtask
  task t_align;
    st(0, 3'h0, 2'h0, 32'h102, 0);
    ck({misaligned, mem_write}, 2'h2);
    st(1, 3'h0, 2'h0, 32'h101, 0);
    ck({misaligned, mem_write}, 2'h2);
    st(1, 3'h3, 2'h1, 32'h100, 17'h00004);
    ck({bad_form, mem_write}, 2'h2);
  endtask
  task t_half;
    store_data = 32'habcd1234;
    st(1, 3'h0, 2'h1, 32'h102, 0);
    ck({mem_data[15:0], mem_byte_en}, {16'habcd, 4'hc});
    st(1, 3'h2, 2'h1, 32'h104, 0);
    ck(base_next, 32'h102);
    ck(word, 32'habcd5678);
    circ_length = 32'h10;
    circ_base = 32'h100;
    st(0, 3'h1, 2'h1, 32'h10c, 0);
    ck(base_next, 32'h100);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // reset for eight cycles, then every scenario back to back
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 rst = 0;
    t_word();
    t_post();
    t_ofs();
    t_refuse();
    t_align();
    t_half();
    end_sim();
  end
endmodule // store_address_unit_bench

// [store_address_unit_properties.sv]
// checker watching the store address unit ports
`timescale 1ns/1ps
module store_props (
  input logic        clk_sys, rst, issue, kind, same_pointer, parallel_req,
  input logic [2:0]  mode,
  input logic [1:0]  base_class,
  input logic [31:0] store_data, base_value, mem_addr, mem_data, base_next,
  input logic [3:0]  mem_byte_en,
  input logic [16:0] offset,
  input logic        mem_write, misaligned, bad_form, parallel_refused,
  input logic        long_encoding, base_write
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // word request through a plain pointer, not paired with another op
  wire wp = issue && !kind && base_class == 2'h0 && !parallel_req;
  chk_word_data: assert property (
    wp && mode == 3'h0 && base_value[1:0] == 2'h0 |=> mem_write &&
    mem_addr == $past(base_value) && mem_data == $past(store_data))
    else $error("word store wrong");
  chk_word_align: assert property (
    wp && mode == 3'h0 && base_value[1:0] != 2'h0 |=> misaligned && !mem_write)
    else $error("misaligned word written");
  chk_post_step: assert property (
    wp && mode == 3'h1 && base_value[1:0] == 2'h0
    |=> base_write && base_next == $past(base_value) + 32'h4)
    else $error("post step wrong");
  chk_half_data: assert property (
    issue && kind && mode == 3'h0 && base_class == 2'h0 && !base_value[0]
    |=> mem_write && mem_data[15:0] == $past(store_data[31:16]))
    else $error("upper half wrong");
  chk_half_align: assert property (
    issue && kind && mode == 3'h0 && base_class == 2'h0 && base_value[0]
    |=> misaligned && !mem_write)
    else $error("odd half written");
  chk_long_refuse: assert property (
    issue && !kind && base_class == 2'h0 && mode inside {3'h4, 3'h5} &&
    offset[1:0] == 2'h0 && parallel_req |=> parallel_refused && !mem_write)
    else $error("parallel long form taken");
  chk_long_flag: assert property (
    wp && mode inside {3'h4, 3'h5} |=> long_encoding)
    else $error("long form flag missing");
  chk_same_ptr: assert property (
    wp && mode == 3'h7 && same_pointer && base_value[1:0] == 2'h0
    |=> mem_write && !base_write)
    else $error("same pointer updated");
  chk_one_answer: assert property (
    issue |=> $onehot({mem_write, misaligned, bad_form, parallel_refused}))
    else $error("answer not unique");
endmodule // store_props
bind store_address_unit store_props u_props (.*);

// [store_unit_defs.vh]
// constants for the store address unit
`ifndef STORE_UNIT_DEFS_VH
`define STORE_UNIT_DEFS_VH
// store kinds
`define KIND_WORD        1'b0
`define KIND_HIGH_HALF   1'b1
// address register classes
`define BASE_POINTER     2'h0
`define BASE_INDEX       2'h1
`define BASE_FRAME       2'h2
// address modes
`define MODE_PLAIN       3'h0
`define MODE_POST_INC    3'h1
`define MODE_POST_DEC    3'h2
`define MODE_SHORT_OFS   3'h3
`define MODE_LONG_ADD    3'h4
`define MODE_LONG_SUB    3'h5
`define MODE_FRAME_NEG   3'h6
`define MODE_REG_INDEX   3'h7
// step sizes in bytes
`define WORD_STEP        32'h00000004
`define HALF_STEP        32'h00000002
// offset field limits in bytes
`define SHORT_OFS_MAX    17'h0003c
`define FRAME_OFS_MIN    17'h00004
`define FRAME_OFS_MAX    17'h00080
`define LONG_OFS_MAX     17'h1fffc
// upper half of a data register
`define UPPER_HI         31
`define UPPER_LO         16
`endif
